/* File: hw/adc_ctrl_cfg.svh */
// Offsets, field positions, reset values and codes for the converter control block.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define OFS_STATUS_CTRL   8'h00
`define OFS_RESULT_HIGH   8'h04
`define OFS_RESULT_LOW    8'h08
`define OFS_CLOCK_CFG     8'h0c

`define SCR_COCO_BIT      7
`define SCR_CONT_BIT      5
`define SCR_CHAN_MSB      4
`define SCR_CHAN_LSB      0
`define SCR_CHAN_RESET    5'h1f

`define CCR_DIV_MSB       7
`define CCR_DIV_LSB       5
`define CCR_CLKSEL_BIT    4
`define CCR_MODE_MSB      3
`define CCR_MODE_LSB      2
`define CCR_DIV_RESET     3'h0
`define CCR_CLKSEL_RESET  1'b0

`define CHAN_PIN_COUNT    7
`define CHAN_HIGH_REF     5'h1d
`define CHAN_GROUND       5'h1e
`define CHAN_POWER_OFF    5'h1f

`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

/* File: hw/adc_ctrl_pkg.sv */
// Types shared by the converter control block.
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      JUST_TRUNC8  = 2'b00,
      JUST_RIGHT   = 2'b01,
      JUST_LEFT    = 2'b10,
      JUST_SIGNED  = 2'b11
   } justify_t;

   typedef enum logic [0:0] {
      CONV_IDLE = 1'b0,
      CONV_BUSY = 1'b1
   } conv_state_t;
endpackage : adc_ctrl_pkg

/* File: hw/adc_mux_result_clock_ctrl.sv */
// Converter control: channel decode, result placement, clock prescaler, AXI4-Lite registers.
// Behaviour
// RULE1: codes 0-6 pins, 1d high ref, 1e ground
// RULE2: unused codes give undefined conversion results
// RULE3: software never selects factory code 11011
// RULE4: all-ones channel code powers converter off
// RULE5: software discards first result after power-up
// RULE6: left mode: high holds upper eight bits
// RULE7: left mode: low holds two bits, zeros
// RULE8: right mode: high holds two bits, zeros
// RULE9: right mode: low holds lower eight bits
// RULE10: truncation: low holds upper eight, no lock
// RULE11: high read freezes low until low read
// RULE12: signed mode is left with msb inverted
// RULE13: prescaler divides by 1,2,4,8 or 16
// RULE14: software keeps converter clock 500k-1MHz
// RULE15: select one is bus, zero external
// RULE16: reset selects external reference clock
// RULE17: external reference only when at least 1MHz
// RULE18: justify codes trunc, right, left, signed
// RULE19: reset selects right justified placement
// RULE20: status write aborts and restarts conversion
// RULE21: both result registers load in one cycle
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "adc_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_mux_result_clock_ctrl #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   // Clock source
   input  wire logic              external_ref_clock,
   // Analog core
   output var  logic [6:0]        chan_pin_sel,
   output var  logic              high_ref_sel,
   output var  logic              ground_sel,
   output var  logic              conv_power,
   output var  logic              conv_start,
   output var  logic              conv_clk_tick,
   input  wire logic              conv_done,
   input  wire logic [9:0]        conv_result
);

   logic [ADDR_W-1:0] aw_addr_r;
   logic              aw_have_r;
   logic [7:0]        w_data_r;
   logic              w_lane_r;
   logic              w_have_r;
   logic [4:0]        chan_r;
   logic              cont_r;
   logic              coco_r;
   logic [2:0]        div_r;
   logic              clk_sel_r;
   logic [1:0]        mode_r;
   logic              lock_r;
   logic [7:0]        result_high_r;
   logic [7:0]        result_low_r;
   logic              ext_q_r;
   logic [3:0]        div_cnt_r;
   adc_ctrl_pkg::conv_state_t state_r;

   // Write path: address and data are captured independently in either order.
   wire aw_hs   = awvalid & awready;
   wire w_hs    = wvalid & wready;
   wire do_wr   = aw_have_r & w_have_r & ~bvalid;
   wire [ADDR_W-1:0] wofs = {aw_addr_r[ADDR_W-1:2], 2'b00};
   wire wr_scr  = do_wr & (wofs == `OFS_STATUS_CTRL) & w_lane_r;
   wire wr_ccr  = do_wr & (wofs == `OFS_CLOCK_CFG) & w_lane_r;
   wire wr_hit  = (wofs == `OFS_STATUS_CTRL) | (wofs == `OFS_RESULT_HIGH) |
                  (wofs == `OFS_RESULT_LOW) | (wofs == `OFS_CLOCK_CFG);
   wire aw_have_nxt = (aw_have_r | aw_hs) & ~do_wr;
   wire w_have_nxt  = (w_have_r | w_hs) & ~do_wr;
   wire bvalid_nxt  = do_wr | (bvalid & ~bready);

   // Read path: one outstanding read, answered the cycle after the address is taken.
   wire ar_hs   = arvalid & arready;
   wire [ADDR_W-1:0] rofs = {araddr[ADDR_W-1:2], 2'b00};
   wire rd_scr  = (rofs == `OFS_STATUS_CTRL);
   wire rd_high = (rofs == `OFS_RESULT_HIGH);
   wire rd_low  = (rofs == `OFS_RESULT_LOW);
   wire rd_ccr  = (rofs == `OFS_CLOCK_CFG);
   wire rd_hit  = rd_scr | rd_high | rd_low | rd_ccr;
   wire rvalid_nxt = ar_hs | (rvalid & ~rready);
   wire [7:0] scr_val = {coco_r, 1'b0, cont_r, chan_r};
   wire [7:0] ccr_val = {div_r, clk_sel_r, mode_r, 2'b00};
   wire [7:0] rd_byte = rd_scr  ? scr_val :
                        rd_high ? result_high_r :
                        rd_low  ? result_low_r :
                        rd_ccr  ? ccr_val : 8'h00;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= 8'h00;
         w_lane_r  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
         arready   <= 1'b0;
         rvalid    <= 1'b0;
         rdata     <= 32'h0000_0000;
         rresp     <= `RESP_OKAY;
      end else begin
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         awready   <= ~aw_have_nxt & ~bvalid_nxt;
         wready    <= ~w_have_nxt & ~bvalid_nxt;
         bvalid    <= bvalid_nxt;
         arready   <= ~rvalid_nxt;
         rvalid    <= rvalid_nxt;
         if (aw_hs) begin
            aw_addr_r <= awaddr;
         end
         if (w_hs) begin
            w_data_r <= wdata[7:0];
            w_lane_r <= wstrb[0];
         end
         if (do_wr) begin
            bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (ar_hs) begin
            rdata <= {24'h00_0000, rd_byte};
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Result formatting for the four placements.
   wire locked   = lock_r & (mode_r != adc_ctrl_pkg::JUST_TRUNC8);
   wire busy     = (state_r == adc_ctrl_pkg::CONV_BUSY);
   wire finish   = conv_done & busy & conv_power;
   // RULE11: discard while frozen
   wire take     = finish & ~locked;
   wire powered  = (chan_r != `CHAN_POWER_OFF);
   wire rd_data  = ar_hs & (rd_high | rd_low);
   wire [7:0] fmt_high;
   wire [7:0] fmt_low;
   // RULE6: left placement
   // RULE8: right placement
   // RULE12: signed msb inverted
   assign fmt_high = (mode_r == adc_ctrl_pkg::JUST_RIGHT)  ? {6'h00, conv_result[9:8]} :
                     (mode_r == adc_ctrl_pkg::JUST_LEFT)   ? conv_result[9:2] :
                     (mode_r == adc_ctrl_pkg::JUST_SIGNED) ? {~conv_result[9], conv_result[8:2]} :
                     8'h00;
   // RULE7: left low bits
   // RULE9: right low byte
   // RULE10: truncated upper bits
   assign fmt_low  = (mode_r == adc_ctrl_pkg::JUST_RIGHT)  ? conv_result[7:0] :
                     (mode_r == adc_ctrl_pkg::JUST_TRUNC8) ? conv_result[9:2] :
                     {conv_result[1:0], 6'h00};

   // Software registers and conversion sequencing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_r        <= `SCR_CHAN_RESET;
         cont_r        <= 1'b0;
         coco_r        <= 1'b0;
         div_r         <= `CCR_DIV_RESET;
         // RULE16: external source default
         clk_sel_r     <= `CCR_CLKSEL_RESET;
         // RULE19: right justified default
         mode_r        <= adc_ctrl_pkg::JUST_RIGHT;
         lock_r        <= 1'b0;
         result_high_r <= 8'h00;
         result_low_r  <= 8'h00;
         state_r       <= adc_ctrl_pkg::CONV_IDLE;
         conv_start    <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         if (wr_scr) begin
            chan_r <= w_data_r[`SCR_CHAN_MSB:`SCR_CHAN_LSB];
            cont_r <= w_data_r[`SCR_CONT_BIT];
         end
         if (wr_ccr) begin
            div_r     <= w_data_r[`CCR_DIV_MSB:`CCR_DIV_LSB];
            // RULE15: clock source bit
            clk_sel_r <= w_data_r[`CCR_CLKSEL_BIT];
            // RULE18: justify field decode
            mode_r    <= w_data_r[`CCR_MODE_MSB:`CCR_MODE_LSB];
         end
         // A completion in the same cycle as a clearing access still sets the flag.
         if (take) begin
            coco_r <= 1'b1;
         end else if (wr_scr | rd_data) begin
            coco_r <= 1'b0;
         end
         // RULE11: high read freezes
         if (ar_hs & rd_low) begin
            lock_r <= 1'b0;
         end else if (ar_hs & rd_high) begin
            lock_r <= 1'b1;
         end
         // RULE21: joint result load
         if (take) begin
            result_high_r <= fmt_high;
            result_low_r  <= fmt_low;
         end
         // RULE20: write restarts conversion
         if (wr_scr) begin
            if (w_data_r[`SCR_CHAN_MSB:`SCR_CHAN_LSB] != `CHAN_POWER_OFF) begin
               state_r    <= adc_ctrl_pkg::CONV_BUSY;
               conv_start <= 1'b1;
            end else begin
               state_r <= adc_ctrl_pkg::CONV_IDLE;
            end
         end else begin
            case (state_r)
               adc_ctrl_pkg::CONV_IDLE: begin
                  state_r <= adc_ctrl_pkg::CONV_IDLE;
               end
               adc_ctrl_pkg::CONV_BUSY: begin
                  if (finish & ~cont_r) begin
                     state_r <= adc_ctrl_pkg::CONV_IDLE;
                  end else if (finish) begin
                     conv_start <= 1'b1;
                  end
               end
               default: begin
                  state_r <= adc_ctrl_pkg::CONV_IDLE;
               end
            endcase
         end
      end
   end

   // Channel decode; codes with no entry route nothing, so their results carry no meaning.
   // RULE1: pin select decode
   genvar gi;
   generate
      for (gi = 0; gi < `CHAN_PIN_COUNT; gi = gi + 1) begin : g_pin
         wire hit = (chan_r == 5'(gi));
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               chan_pin_sel[gi] <= 1'b0;
            end else begin
               chan_pin_sel[gi] <= hit;
            end
         end
      end
   endgenerate

   // RULE1: reference channels
   // RULE2: unused codes unrouted
   // RULE4: power off code
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_ref_sel <= 1'b0;
         ground_sel   <= 1'b0;
         conv_power   <= 1'b0;
      end else begin
         high_ref_sel <= (chan_r == `CHAN_HIGH_REF);
         ground_sel   <= (chan_r == `CHAN_GROUND);
         conv_power   <= powered;
      end
   end

   // Prescaler. The external reference is sampled on aclk, so it must stay well below aclk/2.
   wire ext_rise = external_ref_clock & ~ext_q_r;
   wire src_tick = clk_sel_r ? 1'b1 : ext_rise;
   // RULE13: divide ratio decode
   wire [3:0] div_last = div_r[2]        ? 4'hf :
                         (div_r == 3'h3) ? 4'h7 :
                         (div_r == 3'h2) ? 4'h3 :
                         (div_r == 3'h1) ? 4'h1 : 4'h0;
   wire div_wrap = src_tick & (div_cnt_r >= div_last);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_q_r       <= 1'b0;
         div_cnt_r     <= 4'h0;
         conv_clk_tick <= 1'b0;
      end else begin
         ext_q_r <= external_ref_clock;
         // RULE4: no clock when off
         if (!powered) begin
            div_cnt_r <= 4'h0;
         end else if (div_wrap) begin
            div_cnt_r <= 4'h0;
         end else if (src_tick) begin
            div_cnt_r <= div_cnt_r + 4'h1;
         end
         conv_clk_tick <= powered & div_wrap;
      end
   end

   // RULE5: first result after power-up is left to software to discard.

   // Checks.
   // RULE4: off means idle
   a_power_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_r == `CHAN_POWER_OFF) |=> (!conv_power && !conv_clk_tick))
      else $error("converter active while powered off");
   // RULE1: pin routing
   a_pin_route: assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_r < 5'h07) |=> (chan_pin_sel == 7'(8'h01 << $past(chan_r))))
      else $error("pin select does not follow channel code");
   a_left_high: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
      (take && mode_r == adc_ctrl_pkg::JUST_LEFT) |=> (result_high_r == $past(conv_result[9:2])))
      else $error("left high byte wrong");
   a_left_low_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
      (take && mode_r == adc_ctrl_pkg::JUST_LEFT) |=> (result_low_r == {$past(conv_result[1:0]), 6'h00}))
      else $error("left low byte wrong");
   a_right_high: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
      (take && mode_r == adc_ctrl_pkg::JUST_RIGHT) |=> (result_high_r == {6'h00, $past(conv_result[9:8])}))
      else $error("right high byte wrong");
   a_right_low: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
      (take && mode_r == adc_ctrl_pkg::JUST_RIGHT) |=> (result_low_r == $past(conv_result[7:0])))
      else $error("right low byte wrong");
   a_trunc_low: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
      (finish && mode_r == adc_ctrl_pkg::JUST_TRUNC8) |=> (result_low_r == $past(conv_result[9:2])))
      else $error("truncated result not stored");
   a_lock_freeze: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
      (lock_r && mode_r != adc_ctrl_pkg::JUST_TRUNC8) |=> $stable(result_low_r))
      else $error("low result changed while frozen");
   a_signed_msb: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
      (take && mode_r == adc_ctrl_pkg::JUST_SIGNED) |=> (result_high_r[7] != $past(conv_result[9])))
      else $error("signed msb not inverted");
   a_div_gap: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
      (conv_clk_tick && div_r != 3'h0 && $stable(div_r)) |=> !conv_clk_tick)
      else $error("converter clock faster than divide ratio");
   a_reset_defaults: assert property (@(posedge aclk) // RULE16
      $rose(aresetn) |-> (!clk_sel_r && mode_r == adc_ctrl_pkg::JUST_RIGHT))
      else $error("clock select or mode wrong after reset");
   a_write_restart: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
      (wr_scr && w_data_r[4:0] != `CHAN_POWER_OFF) |=> (conv_start && busy))
      else $error("status write did not start conversion");
   a_joint_load: assert property (@(posedge aclk) disable iff (!aresetn) // RULE21
      ($changed(result_high_r) || $changed(result_low_r)) |-> $past(take))
      else $error("result registers loaded outside a completion");

   c_left_take: cover property (@(posedge aclk) take && mode_r == adc_ctrl_pkg::JUST_LEFT);
   c_locked_drop: cover property (@(posedge aclk) finish && locked);
   c_div16_tick: cover property (@(posedge aclk) conv_clk_tick && div_r[2]);
   c_cont_restart: cover property (@(posedge aclk) finish && cont_r ##1 conv_start);

endmodule : adc_mux_result_clock_ctrl

`default_nettype wire

/* File: verif/adc_mux_result_clock_ctrl_tb.sv */
// Self-checking bench for the converter control block.
`include "adc_ctrl_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_mux_result_clock_ctrl_tb;
   localparam int LIMIT = 20000;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        external_ref_clock = 1'b0;
   logic        conv_done = 1'b0;
   logic [9:0]  conv_result = 10'h0;
   logic [6:0]  chan_pin_sel;
   logic        high_ref_sel, ground_sel, conv_power, conv_start, conv_clk_tick;
   int          fail_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          starts = 0;
   int          ticks = 0;

   adc_mux_result_clock_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .external_ref_clock(external_ref_clock),
      .chan_pin_sel(chan_pin_sel), .high_ref_sel(high_ref_sel), .ground_sel(ground_sel),
      .conv_power(conv_power), .conv_start(conv_start), .conv_clk_tick(conv_clk_tick),
      .conv_done(conv_done), .conv_result(conv_result));

   initial begin
      forever #50 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc % 5 == 4) begin
         external_ref_clock <= ~external_ref_clock;
      end
      if (conv_start === 1'b1) starts <= starts + 1;
      if (conv_clk_tick === 1'b1) ticks <= ticks + 1;
      if (cyc == LIMIT) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h3;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 100) begin
         @(posedge aclk);
         n++;
         if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            bready <= 1'b0;
            n = 1000;
         end
      end
      if (n < 1000) chk("write answer", 32'h1, 32'h0);
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      n = 0;
      d = 32'hx;
      resp = 2'h3;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 100) begin
         @(posedge aclk);
         n++;
         if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            n = 1000;
         end
      end
      if (n < 1000) chk("read answer", 32'h1, 32'h0);
   endtask : axi_read

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_write(a, {24'h0, d}, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [31:0] v;
      logic [1:0]  r;
      axi_read(a, v, r);
      d = v[7:0];
   endtask : rd

   task automatic set_cfg(input logic [2:0] dv, input logic bus, input logic [1:0] m);
      wr(`OFS_CLOCK_CFG, {dv, bus, m, 2'b00});
   endtask : set_cfg

   task automatic conv(input logic [9:0] v);
      @(posedge aclk);
      conv_done <= 1'b1;
      conv_result <= v;
      @(posedge aclk);
      conv_done <= 1'b0;
      conv_result <= ~v;
      repeat (2) @(posedge aclk);
   endtask : conv

   function automatic logic [15:0] place(input logic [1:0] m, input logic [9:0] v);
      case (m)
         2'b00: place = {8'h00, v[9:2]};
         2'b01: place = {6'h00, v};
         2'b10: place = {v, 6'h00};
         default: place = {~v[9], v[8:0], 6'h00};
      endcase
   endfunction : place

   task automatic t_reset_bus;
      logic [31:0] v;
      logic [1:0]  r;
      axi_read(`OFS_CLOCK_CFG, v, r);
      chk("clock cfg reset", 32'h04, v);
      axi_read(`OFS_STATUS_CTRL, v, r);
      chk("status reset", 32'h1f, v);
      chk("power at reset", 32'h0, conv_power);
      axi_read(8'h10, v, r);
      chk("unmapped read resp", `RESP_SLVERR, r);
      axi_write(8'h10, 32'h55, r);
      chk("unmapped write resp", `RESP_SLVERR, r);
   endtask : t_reset_bus

   task automatic t_channels;
      logic [4:0] codes [11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h1d, 5'h1e, 5'h1f};
      logic [9:0] e;
      int s0;
      foreach (codes[i]) begin
         s0 = starts;
         wr(`OFS_STATUS_CTRL, {3'b000, codes[i]});
         repeat (3) @(posedge aclk);
         e = {(codes[i] < 5'h07) ? 7'(1 << codes[i]) : 7'h00, codes[i] == 5'h1d, codes[i] == 5'h1e,
              codes[i] != 5'h1f};
         chk("mux select", e, {chan_pin_sel, high_ref_sel, ground_sel, conv_power});
         chk("start pulses", codes[i] != 5'h1f, starts - s0);
      end
   endtask : t_channels

   task automatic t_modes;
      logic [9:0]  vals [2] = '{10'h2d6, 10'h129};
      logic [7:0]  h, l;
      logic [15:0] e;
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h000);
      for (int m = 0; m < 4; m++) begin
         foreach (vals[k]) begin
            set_cfg(3'h4, 1'b1, 2'(m));
            wr(`OFS_STATUS_CTRL, 8'h00);
            conv(vals[k]);
            rd(`OFS_RESULT_HIGH, h);
            rd(`OFS_RESULT_LOW, l);
            e = place(2'(m), vals[k]);
            chk("result pair", e, {h, l});
         end
      end
   endtask : t_modes

   task automatic t_lock;
      logic [7:0] d;
      set_cfg(3'h4, 1'b1, 2'b01);
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h2a5);
      rd(`OFS_RESULT_HIGH, d);
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h15a);
      rd(`OFS_RESULT_LOW, d);
      chk("low frozen after high read", 32'ha5, d);
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h15a);
      rd(`OFS_RESULT_LOW, d);
      chk("low after unlock", 32'h5a, d);
      set_cfg(3'h4, 1'b1, 2'b00);
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h2a5);
      rd(`OFS_RESULT_HIGH, d);
      wr(`OFS_STATUS_CTRL, 8'h00);
      conv(10'h15a);
      rd(`OFS_RESULT_LOW, d);
      chk("truncation without lock", 32'h56, d);
      wr(`OFS_STATUS_CTRL, 8'h1f);
      conv(10'h3ff);
      rd(`OFS_RESULT_LOW, d);
      chk("no result while off", 32'h56, d);
   endtask : t_lock

   // Continuous mode: the completion restarts the converter and sets the completion flag.
   task automatic t_cont;
      logic [7:0] d;
      int         s0;
      s0 = starts;
      wr(`OFS_STATUS_CTRL, 8'h20);
      conv(10'h0c8);
      chk("continuous starts", 32'h2, starts - s0);
      rd(`OFS_STATUS_CTRL, d);
      chk("status after completion", 32'ha0, d);
      conv(10'h3fc);
      rd(`OFS_RESULT_LOW, d);
      chk("continuous low update", 32'hff, d);
      rd(`OFS_STATUS_CTRL, d);
      chk("status after result read", 32'h20, d);
   endtask : t_cont

   task automatic t_prescale;
      logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      int         per [6] = '{1, 2, 4, 8, 16, 16};
      int         t0;
      wr(`OFS_STATUS_CTRL, 8'h00);
      foreach (divs[i]) begin
         set_cfg(divs[i], 1'b1, 2'b01);
         repeat (20) @(posedge aclk);
         t0 = ticks;
         repeat (64) @(posedge aclk);
         chk("bus clock ticks", 64 / per[i], ticks - t0);
      end
      for (int d = 0; d < 2; d++) begin
         set_cfg(3'(d), 1'b0, 2'b01);
         repeat (40) @(posedge aclk);
         t0 = ticks;
         repeat (640) @(posedge aclk);
         chk("reference ticks", 64 >> d, ticks - t0);
      end
   endtask : t_prescale

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset_bus();
      t_channels();
      t_modes();
      t_lock();
      t_cont();
      t_prescale();
      test_done();
   end
endmodule : adc_mux_result_clock_ctrl_tb

`default_nettype wire
